/* File: logic/lcd_cmd_dec.sv */
// command decoder, RAM addressing and row scan for the dot-matrix driver
`timescale 1ns/1ps
`include "lcd_regs.svh"
// How it works
// R1: bits 6..2 all ones set the start bank from the two low bits.
// R2: the start bank is the top displayed row; scanning offsets from it.
// R3: pattern 110 in bits 6..4 loads the subaddress counter from bits 3..0.
// R4: pattern 111 selects RAM access with walk order in bits 3..2.
// R5: the master never sends walk order 11 in a RAM-access command.
// R6: the two low bits of RAM-access load the row pointer.
// R7: bit 6 clear loads the six-bit column pointer.
// R8: RAM is read or written only in mixed mode.
// R9: own subaddress is fixed at zero in mixed mode.
// R10: companion drivers take subaddresses from one upward.
// R11: master sets subaddress, column and bank before data.
// R12: each later byte goes to the location advanced by the walk order.
// R13: subaddress counter steps to the next device when a range fills.
// R14: subaddress counter wraps from 15 to zero.
// R15: rows are scanned continuously, count set by the multiplex setting.
// R16: output shows blank, normal, all on or inverse per the show field.
// R17: bit 7 set means another command follows, clear means data follows.
// R18: commands come only in write transfers; reads return RAM data.
// R19: data is stored or returned only when subaddress equals own.
// R20: pointer advances on every data byte; subaddress steps only when the column passes the end.
// R21: bit 6 is checked first, then the set-start-bank pattern before RAM access.
// R22: outside mixed mode pointers still move but no RAM write or acknowledge.
module lcd_cmd_dec
    import lcd_pkg::*;
#(
    parameter int COLS = 40,
    parameter int BANKS = 4
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // byte stream from the bus front end
    input wire logic byte_valid_in,
    output logic byte_ready_out,
    input wire lcd_req_t byte_in,
    input wire logic frame_start_in,
    // answer towards the bus front end
    output logic rsp_valid_out,
    input wire logic rsp_ready_in,
    output lcd_rsp_t rsp_out,
    // display scan
    input wire logic scan_tick_in,
    output logic [7:0] col_dots_out,
    output logic [4:0] scan_row_out,
    // status
    output logic mixed_mode_out,
    output logic [1:0] start_bank_out,
    output logic [3:0] subaddr_out
);
    typedef struct packed {
        logic [BANKS-1:0][COLS-1:0][7:0] ram;
        logic cmd_next;
        logic mixed;
        lcd_show_t show;
        logic [1:0] mux;
        logic [1:0] start_bank;
        logic [3:0] sub;
        lcd_walk_t walk;
        logic [1:0] row;
        logic [5:0] col;
        logic [5:0] col_base;
        logic [4:0] scan;
        logic [7:0] dots;
        logic rvalid;
        lcd_rsp_t rsp;
    } lcd_st_t;
    lcd_st_t s_q;
    lcd_st_t s_d;
    logic buf_valid;
    logic buf_ready;
    lcd_req_t buf_byte;
    logic take;
    logic [7:0] raw;
    logic hit;
    logic [4:0] rows_used;
    logic [1:0] bank_now;
    logic [7:0] line;

    function automatic logic [4:0] mux_rows(input logic [1:0] m);
        if (m == `LCD_MUX_8)
            mux_rows = 5'h07;
        else if (m == `LCD_MUX_16)
            mux_rows = 5'h0F;
        else if (m == `LCD_MUX_24)
            mux_rows = 5'h17;
        else
            mux_rows = 5'h1F;
    endfunction : mux_rows

    // two-entry buffer so a stall on the answer side loses no byte
    lcd_buf2 #(
        .WIDTH($bits(lcd_req_t))
    ) u_buf (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .in_valid_in(byte_valid_in),
        .in_ready_out(byte_ready_out),
        .in_data_in(byte_in),
        .out_valid_out(buf_valid),
        .out_ready_in(buf_ready),
        .out_data_out(buf_byte)
    );

    // a byte is taken only when no answer is waiting or the waiting answer leaves in the same cycle
    assign buf_ready = !s_q.rvalid || rsp_ready_in;
    assign take = buf_valid && buf_ready;
    assign raw = buf_byte.data;
    assign hit = s_q.mixed && (s_q.sub == `LCD_OWN_SUB); // R8 R9 R19 R22

    always_comb
    begin
        s_d = s_q;
        rows_used = mux_rows(s_q.mux);
        bank_now = 2'h0;
        line = 8'h00;
        if (s_q.rvalid && rsp_ready_in)
        begin
            s_d.rvalid = 1'b0;
        end
        if (frame_start_in)
        begin
            s_d.cmd_next = 1'b1;
        end
        else if (take)
        begin
            s_d.rvalid = 1'b1;
            s_d.rsp = '0;
            if (!buf_byte.is_read && s_q.cmd_next)
            begin
                s_d.rsp.acked = 1'b1;
                s_d.cmd_next = raw[7]; // R17 R18
                if (!raw[6]) // R21
                begin
                    s_d.col = raw[5:0]; // R7
                    s_d.col_base = raw[5:0];
                end
                else if (raw[6:2] == `LCD_BANK_PAT) // R1 R21
                begin
                    s_d.start_bank = raw[1:0];
                end
                else if (raw[6:4] == `LCD_RAMA_PAT) // R4
                begin
                    s_d.walk = lcd_walk_t'(raw[3:2]);
                    s_d.row = raw[1:0]; // R6
                end
                else if (raw[6:4] == `LCD_DSEL_PAT)
                begin
                    s_d.sub = raw[3:0]; // R3
                end
                else if (raw[6:5] == `LCD_MODE_PAT)
                begin
                    s_d.mixed = raw[4];
                    s_d.show = lcd_show_t'(raw[3:2]); // R16
                    s_d.mux = raw[1:0];
                end
            end
            else
            begin
                // data byte: write or read at the pointer, then advance
                if (hit)
                begin
                    s_d.rsp.acked = 1'b1;
                    if (buf_byte.is_read)
                    begin
                        s_d.rsp.data = s_q.ram[s_q.row][s_q.col]; // R18 R19
                    end
                    else
                    begin
                        s_d.ram[s_q.row][s_q.col] = raw; // R8 R19
                    end
                end
                // R12 R20
                if (s_q.walk == LCD_WALK_CHAR)
                begin
                    if (s_q.col[2:0] != 3'h7)
                    begin
                        s_d.col = s_q.col + 6'h01;
                    end
                    else if (s_q.row != 2'h3)
                    begin
                        s_d.col = s_q.col - 6'h07;
                        s_d.row = s_q.row + 2'h1;
                    end
                    else
                    begin
                        s_d.col = s_q.col + 6'h01;
                        s_d.row = 2'h0;
                    end
                end
                else if (s_q.walk == LCD_WALK_HALF)
                begin
                    if (s_q.row[0] == 1'b0)
                    begin
                        s_d.row = s_q.row + 2'h1;
                    end
                    else
                    begin
                        s_d.row = {s_q.row[1], 1'b0};
                        s_d.col = s_q.col + 6'h01;
                    end
                end
                else
                begin
                    if (s_q.row != 2'h3)
                    begin
                        s_d.row = s_q.row + 2'h1;
                    end
                    else
                    begin
                        s_d.row = 2'h0;
                        s_d.col = s_q.col + 6'h01;
                    end
                end
                // column past the end moves to the next device
                if (s_d.col > `LCD_COL_LAST)
                begin
                    s_d.col = s_q.col_base;
                    s_d.sub = s_q.sub + 4'h1; // R13 R14
                end
            end
        end
        // continuous row scan from the start bank
        if (scan_tick_in)
        begin
            if (s_q.scan >= rows_used)
            begin
                s_d.scan = 5'h00; // R15
            end
            else
            begin
                s_d.scan = s_q.scan + 5'h01;
            end
        end
        bank_now = s_q.start_bank + s_q.scan[4:3]; // R2
        for (int i = 0; i < 8; i++)
        begin
            // one dot of the current scan row from each of the columns 8 to 15
            line[i] = s_q.ram[bank_now][{3'h1, 3'(i)}][s_q.scan[2:0]];
        end
        if (s_q.show == LCD_SHOW_BLANK) // R16
            s_d.dots = 8'h00;
        else if (s_q.show == LCD_SHOW_NORMAL)
            s_d.dots = line;
        else if (s_q.show == LCD_SHOW_ALL)
            s_d.dots = 8'hFF;
        else
            s_d.dots = ~line;
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            s_q <= '0;
            s_q.cmd_next <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rsp_valid_out = s_q.rvalid;
    assign rsp_out = s_q.rsp;
    assign col_dots_out = s_q.dots;
    assign scan_row_out = s_q.scan;
    assign mixed_mode_out = s_q.mixed;
    assign start_bank_out = s_q.start_bank;
    assign subaddr_out = s_q.sub;
endmodule : lcd_cmd_dec

/* File: logic/lcd_regs.svh */
// constants for the display RAM command decoder
`ifndef LCD_REGS_SVH
`define LCD_REGS_SVH
`define LCD_BANKS 3'h4
`define LCD_COLS 6'h28
`define LCD_COL_LAST 6'h27
`define LCD_OWN_SUB 4'h0
`define LCD_SUB_LAST 4'hF
`define LCD_BANK_PAT 5'h1F
`define LCD_DSEL_PAT 3'h6
`define LCD_RAMA_PAT 3'h7
`define LCD_MODE_PAT 2'h2
`define LCD_MUX_8 2'h1
`define LCD_MUX_16 2'h2
`define LCD_MUX_24 2'h3
`define LCD_MUX_32 2'h0
`endif

/* File: logic/lcd_pkg.sv */
// types for the display RAM command decoder
package lcd_pkg;
    typedef enum logic [1:0] {LCD_WALK_CHAR, LCD_WALK_HALF, LCD_WALK_FULL, LCD_WALK_BAD} lcd_walk_t;
    typedef enum logic [1:0] {LCD_SHOW_BLANK, LCD_SHOW_NORMAL, LCD_SHOW_ALL, LCD_SHOW_INV} lcd_show_t;
    typedef struct packed {
        logic [7:0] data;
        logic is_read;
    } lcd_req_t;
    typedef struct packed {
        logic [7:0] data;
        logic acked;
    } lcd_rsp_t;
endpackage : lcd_pkg

/* File: logic/lcd_buf2.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module lcd_buf2
    import lcd_pkg::*;
#(
    parameter int WIDTH = 9
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic rd;
        logic wr;
        logic [1:0] cnt;
    } lcd_buf_st_t;
    lcd_buf_st_t s_q;
    lcd_buf_st_t s_d;
    logic push;
    logic pop;
    always_comb
    begin
        s_d = s_q;
        push = in_valid_in && (s_q.cnt != 2'h2);
        pop = out_ready_in && (s_q.cnt != 2'h0);
        if (push)
        begin
            s_d.mem[s_q.wr] = in_data_in;
            s_d.wr = ~s_q.wr;
        end
        if (pop)
        begin
            s_d.rd = ~s_q.rd;
        end
        s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
    end
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
    assign in_ready_out = (s_q.cnt != 2'h2);
    assign out_valid_out = (s_q.cnt != 2'h0);
    assign out_data_out = s_q.mem[s_q.rd];
endmodule : lcd_buf2

/* File: bench/lcd_cmd_dec_props.sv */
// assertions on the command decoder ports
`timescale 1ns/1ps
module lcd_cmd_dec_props
    import lcd_pkg::*;
(
    // watched ports
    input logic sys_clk_in,
    input logic arst_n_in,
    input logic byte_valid_in,
    input logic byte_ready_out,
    input logic rsp_valid_out,
    input logic rsp_ready_in,
    input lcd_rsp_t rsp_out,
    input logic mixed_mode_out,
    input logic [1:0] start_bank_out,
    input logic [3:0] subaddr_out
);
    logic [2:0] pend_q, pend_d;
    // bytes taken but not yet answered and handed back
    always_comb pend_d = pend_q + 3'(byte_valid_in && byte_ready_out) - 3'(rsp_valid_out && rsp_ready_in);
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
        if (!arst_n_in)
            pend_q <= 3'h0;
        else
            pend_q <= pend_d;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    a_answer_holds:
        assert property (rsp_valid_out && !rsp_ready_in |=> rsp_valid_out && $stable(rsp_out)) else $error("held answer moved");
    a_answer_comes:
        assert property (byte_valid_in && byte_ready_out |-> ##[1:40] rsp_valid_out) else $error("byte not answered");
    a_answer_cause:
        assert property (rsp_valid_out |-> pend_q != 3'h0) else $error("answer without byte");
    a_full_refuses:
        assert property (pend_q == 3'h3 |-> !byte_ready_out) else $error("full buffer still ready");
    a_bank_on_answer:
        assert property (!$stable(start_bank_out) |-> rsp_valid_out) else $error("bank moved without byte");
    a_sub_on_answer:
        assert property (!$stable(subaddr_out) |-> rsp_valid_out) else $error("subaddress moved without byte");
    a_mode_on_answer:
        assert property (!$stable(mixed_mode_out) |-> rsp_valid_out) else $error("mode moved without byte");
    a_reset_clears:
        assert property (disable iff (1'b0) !arst_n_in |-> !rsp_valid_out && !mixed_mode_out && subaddr_out == 4'h0)
            else $error("reset left state");
    c_acked: cover property (rsp_valid_out && rsp_ready_in && rsp_out.acked);
    c_refused: cover property (!byte_ready_out);
    c_sub_wrap: cover property ($past(subaddr_out) == 4'hF && subaddr_out == 4'h0);
endmodule : lcd_cmd_dec_props
bind lcd_cmd_dec lcd_cmd_dec_props chk (.sys_clk_in, .arst_n_in, .byte_valid_in, .byte_ready_out, .rsp_valid_out,
    .rsp_ready_in, .rsp_out, .mixed_mode_out, .start_bank_out, .subaddr_out);

/* File: bench/lcd_master_model.sv */
// bus master model that offers bytes and takes answers
`timescale 1ns/1ps
module lcd_master_model
    import lcd_pkg::*;
(
    // clock
    input logic sys_clk_in,
    // byte offer
    output logic byte_valid_out,
    input logic byte_ready_in,
    output lcd_req_t byte_out,
    output logic frame_start_out,
    // answer
    input logic rsp_valid_in,
    output logic rsp_ready_out,
    input lcd_rsp_t rsp_in
);
    logic hung = 1'b0;
    initial {byte_valid_out, byte_out, frame_start_out, rsp_ready_out} = '0;
    task frame();
        @(negedge sys_clk_in);
        frame_start_out = 1'b1;
        @(negedge sys_clk_in);
        frame_start_out = 1'b0;
    endtask : frame
    // holds the byte until taken, then drives its inverse; walk order 11 is never sent
    task put(input logic [7:0] d, input logic rd);
        int i;
        @(negedge sys_clk_in);
        byte_out = {d, rd};
        byte_valid_out = 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge sys_clk_in);
            if (byte_ready_in)
                break;
        end
        hung |= (i == 50);
        @(negedge sys_clk_in);
        byte_valid_out = 1'b0;
        byte_out = ~byte_out;
    endtask : put
    // slow stalls the answer for that many cycles first
    task get(output lcd_rsp_t r, input int slow);
        int i;
        repeat (slow) @(negedge sys_clk_in);
        @(negedge sys_clk_in);
        rsp_ready_out = 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge sys_clk_in);
            if (rsp_valid_in)
                break;
        end
        hung |= (i == 50);
        r = rsp_in;
        @(negedge sys_clk_in);
        rsp_ready_out = 1'b0;
    endtask : get
endmodule : lcd_master_model

/* File: bench/lcd_cmd_dec_bench.sv */
// self-checking bench for the command decoder
`timescale 1ns/1ps
module lcd_cmd_dec_bench
    import lcd_pkg::*;
();
    logic sys_clk_in = 1'b0;
    logic arst_n_in = 1'b1;
    logic scan_tick_in = 1'b0;
    logic byte_valid_in, byte_ready_out, frame_start_in, rsp_valid_out, rsp_ready_in, mixed_mode_out;
    lcd_req_t byte_in;
    lcd_rsp_t rsp_out, r;
    logic [1:0] start_bank_out;
    logic [3:0] subaddr_out;
    logic [7:0] col_dots_out;
    logic [4:0] scan_row_out, top_row;
    int fails = 0;
    int n_tests = 0;
    int n;
    always #5 sys_clk_in = ~sys_clk_in;
    always @(negedge sys_clk_in) scan_tick_in <= ~scan_tick_in;
    lcd_cmd_dec dut (.sys_clk_in, .arst_n_in, .byte_valid_in, .byte_ready_out, .byte_in, .frame_start_in,
        .rsp_valid_out, .rsp_ready_in, .rsp_out, .scan_tick_in, .col_dots_out, .scan_row_out,
        .mixed_mode_out, .start_bank_out, .subaddr_out);
    lcd_master_model mdl (.sys_clk_in, .byte_valid_out(byte_valid_in), .byte_ready_in(byte_ready_out),
        .byte_out(byte_in), .frame_start_out(frame_start_in), .rsp_valid_in(rsp_valid_out),
        .rsp_ready_out(rsp_ready_in), .rsp_in(rsp_out));
    task give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
        if (mdl.hung)
        begin
            fails++;
            give_verdict();
        end
    endtask : chk
    task xf(input logic [7:0] d, input logic rd, input logic ack, input int slow);
        mdl.put(d, rd);
        mdl.get(r, slow);
        chk({7'h0, r.acked}, {7'h0, ack});
    endtask : xf
    // new frame setting subaddress, access mode with row, and column
    task setup(input logic [7:0] sel, input logic [7:0] acc, input logic [7:0] col);
        mdl.frame();
        xf(sel, 1'b0, 1'b1, 0);
        xf(acc, 1'b0, 1'b1, 0);
        xf(col, 1'b0, 1'b1, 0);
    endtask : setup
    // waits for a scan row, then compares the dots registered from it one edge later
    task dots_at(input logic [4:0] v, input logic [7:0] e);
        int k;
        k = 0;
        @(negedge sys_clk_in);
        while (scan_row_out !== v && k < 100)
        begin
            @(negedge sys_clk_in);
            k++;
        end
        @(negedge sys_clk_in);
        if (k == 100)
            fails++;
        chk(col_dots_out, e);
    endtask : dots_at
    initial
    begin
        #1 arst_n_in = 1'b0;
        repeat (5) @(negedge sys_clk_in);
        arst_n_in = 1'b1;
        chk({byte_ready_out, mixed_mode_out, start_bank_out, subaddr_out}, 8'h80);
        $display("reset test done");
        mdl.frame();
        xf(8'h00, 1'b0, 1'b1, 0);
        xf(8'h5A, 1'b0, 1'b0, 0);
        $display("row mode test done");
        mdl.frame();
        for (int b = 1; b < 5; b++)
        begin
            xf(8'hFC | 8'(b % 4), 1'b0, 1'b1, 0);
            chk({6'h0, start_bank_out}, 8'(b % 4));
        end
        $display("start bank test done");
        mdl.frame();
        xf(8'hD4, 1'b0, 1'b1, 0);
        chk({7'h0, mixed_mode_out}, 8'h01);
        setup(8'hE0, 8'hF0, 8'h08);
        xf(8'hA5, 1'b0, 1'b1, 0);
        xf(8'h3C, 1'b0, 1'b1, 2);
        setup(8'hE0, 8'hF0, 8'h08);
        mdl.frame();
        xf(8'h00, 1'b1, 1'b1, 3);
        chk(r.data, 8'hA5);
        xf(8'h00, 1'b1, 1'b1, 0);
        chk(r.data, 8'h3C);
        $display("mixed mode test done");
        dots_at(5'h02, 8'h03);
        xf(8'hDC, 1'b0, 1'b1, 0);
        dots_at(5'h02, 8'hFC);
        xf(8'hD5, 1'b0, 1'b1, 0);
        repeat (4) @(negedge sys_clk_in);
        top_row = 5'h00;
        for (int i = 0; i < 40; i++)
        begin
            @(negedge sys_clk_in);
            if (scan_row_out > top_row)
                top_row = scan_row_out;
        end
        chk({3'h0, top_row}, 8'h07);
        $display("display test done");
        setup(8'hEF, 8'hF8, 8'h26);
        chk({4'h0, subaddr_out}, 8'h0F);
        for (int i = 0; i < 8; i++)
            xf(8'hC3, 1'b0, 1'b0, 0);
        chk({4'h0, subaddr_out}, 8'h00);
        xf(8'h81, 1'b0, 1'b1, 0);
        $display("subaddress wrap test done");
        mdl.frame();
        n = 0;
        while (byte_ready_out === 1'b1 && n < 6)
        begin
            mdl.put(8'hFD, 1'b0);
            n++;
        end
        chk({7'h0, byte_ready_out}, 8'h00);
        for (int i = 0; i < n; i++)
        begin
            mdl.get(r, 1);
            chk({7'h0, r.acked}, 8'h01);
        end
        chk({byte_ready_out, 5'h0, start_bank_out}, 8'h81);
        $display("buffer test done");
        @(negedge sys_clk_in);
        arst_n_in = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        arst_n_in = 1'b1;
        chk({byte_ready_out, mixed_mode_out, start_bank_out, subaddr_out}, 8'h80);
        $display("second reset test done");
        give_verdict();
    end
endmodule : lcd_cmd_dec_bench
